//--- logic/real_time_counter_core.sv
// Real-time counter core with periodic tick timer
// Summary of operation
// - Counter advances per prescaled tick, compared to period and compare.
// - Compare flag and event rise on the count after a compare match.
// - On the count after period match: overflow flag, event, wrap to zero.
// - Sixteen-bit prescaler divides the reference by a software power of two.
// - Reference is crystal, external clock, low-power oscillator or it divided by 32.
// - Correction acts only in intervals that begin with the crystal as the selected reference.
// - Correction steps of one ppm, limited to 127 either way.
// - Correction skips prescaler counts when slow, inserts counts when fast.
// - Tick timer flags every n-th reference period, n from 4 to 32768.
// - Tick timer level events at reference divided by 64 up to 8192.
// - Tick timer works whether or not the counter is enabled.
// - Counting runs while the enable bit is one, stops when zero.
// - Keeps counting in sleep; its requests can wake the device.
// - Prescaler stops when both functions are off, runs if either is on.
// - Correction cycles are spread over each million reference cycles.
// - Request stands while flag and enable are set, until flag clears.
`timescale 1ns/1ps
`default_nettype none
module real_time_counter_core #(
    parameter int CORR_INTERVAL = rtc_pkg::CORR_INTERVAL
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               xtal_tick,
    input  wire logic               ext_clk_tick,
    input  wire logic               ulp_tick,
    input  wire rtc_pkg::rtc_ctrl_t ctrl,
    input  wire rtc_pkg::pit_ctrl_t pit_ctrl,
    input  wire rtc_pkg::flags_t    irq_enable,
    input  wire rtc_pkg::flags_t    flag_clear,
    input  wire logic [15:0]        period_value,
    input  wire logic [15:0]        compare_value,
    output logic [15:0]             count_value,
    output rtc_pkg::flags_t         flags,
    output logic                    rtc_irq,
    output logic                    pit_irq,
    output logic                    cmp_event,
    output logic                    ovf_event,
    output logic                    counter_running,
    output logic [7:0]              pit_events
);

    // Low-power oscillator divider state
    logic [4:0]  ulp_div_reg;
    logic [4:0]  ulp_div_next;
    logic        ulp32_tick_reg;
    logic        ulp32_tick_next;

    // Reference and prescaler
    logic        ref_tick;
    logic        pre_run;
    logic        corr_on;
    logic [15:0] pre_cnt;
    logic [15:0] prev_reg;

    // Counter
    logic        cnt_tick;
    logic        count_step;
    logic        hit_per;
    logic        hit_cmp;
    logic        ovf_set;
    logic        cmp_set;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    // Periodic tick timer
    logic        pit_sel_ok;
    logic [3:0]  pit_shift;
    logic        pit_hit;

    // Requests from the flag cells
    rtc_pkg::flags_t req;
    rtc_pkg::flags_t set_vec;

    // Divide the low-power oscillator by 32
    assign ulp_div_next    = ulp_tick ? ulp_div_reg + 5'h01 : ulp_div_reg;
    assign ulp32_tick_next = ulp_tick && (ulp_div_reg == rtc_pkg::ULP_DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ulp_div_reg    <= 5'h00;
            ulp32_tick_reg <= 1'b0;
        end else begin
            ulp_div_reg    <= ulp_div_next;
            ulp32_tick_reg <= ulp32_tick_next;
        end
    end

    // Reference source selection
    assign ref_tick =
        (ctrl.clock_source_select == rtc_pkg::SRC_XTAL) ? xtal_tick :
        (ctrl.clock_source_select == rtc_pkg::SRC_EXT)  ? ext_clk_tick :
        (ctrl.clock_source_select == rtc_pkg::SRC_ULP)  ? ulp_tick :
        ulp32_tick_reg;

    // Shared prescaler runs when either function is on
    assign pre_run = ctrl.counter_enable_bit | pit_ctrl.pit_enable;

    // Correction only on the crystal
    assign corr_on = ctrl.corr_enable &&
        (ctrl.clock_source_select == rtc_pkg::SRC_XTAL);

    ref_prescaler #(
        .CORR_INTERVAL (CORR_INTERVAL)
    ) u_prescaler (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .run        (pre_run),
        .ref_tick   (ref_tick),
        .corr_on    (corr_on),
        .corr_value (ctrl.corr_value),
        .pre_cnt    (pre_cnt)
    );

    // Correction interval must fit the 20-bit interval counter
    generate
        if (CORR_INTERVAL < 256 || CORR_INTERVAL > 1048575) begin : g_bad_interval
            $error("CORR_INTERVAL out of range");
        end
    endgenerate

    // Previous prescaler value for carry detection
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prev_reg <= rtc_pkg::PRE_RESET;
        end else begin
            prev_reg <= pre_cnt;
        end
    end

    // Prescaled tick at the selected power of two
    assign cnt_tick   = rtc_pkg::crossed(prev_reg, pre_cnt, ctrl.prescale);
    assign count_step = cnt_tick & ctrl.counter_enable_bit;

    // Compare against period and compare values
    assign hit_per = cnt_reg == period_value;
    assign hit_cmp = cnt_reg == compare_value;
    assign ovf_set = count_step & hit_per;
    assign cmp_set = count_step & hit_cmp;

    // Next count: hold, wrap on period or advance
    assign cnt_next = !count_step ? cnt_reg
                    : hit_per ? rtc_pkg::CNT_RESET
                    : cnt_reg + 16'h0001;

    // Counter, events and status registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg         <= rtc_pkg::CNT_RESET;
            cmp_event       <= 1'b0;
            ovf_event       <= 1'b0;
            counter_running <= 1'b0;
        end else begin
            cnt_reg         <= cnt_next;
            cmp_event       <= cmp_set;
            ovf_event       <= ovf_set;
            counter_running <= ctrl.counter_enable_bit;
        end
    end

    assign count_value = cnt_reg;

    // Tick timer period: select k gives 2 to the k+1 periods
    assign pit_sel_ok = (pit_ctrl.period >= rtc_pkg::PIT_SEL_MIN) &&
                        (pit_ctrl.period <= rtc_pkg::PIT_SEL_MAX);
    assign pit_shift  = pit_ctrl.period + 4'h1;

    // Tick timer hit, independent of the counter enable
    assign pit_hit = pit_ctrl.pit_enable && pit_sel_ok &&
                     rtc_pkg::crossed(prev_reg, pre_cnt, pit_shift);

    // Level events straight from prescaler bits 5 to 12
    assign pit_events = pre_cnt[rtc_pkg::PIT_EVT_LSB +: rtc_pkg::PIT_EVT_N];

    // Flag cells, one per source
    assign set_vec = '{cmp: cmp_set, ovf: ovf_set, periodic_tick_timer: pit_hit};

    sticky_flag u_cmp_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set      (set_vec.cmp),
        .clear    (flag_clear.cmp),
        .enable   (irq_enable.cmp),
        .flag     (flags.cmp),
        .request  (req.cmp)
    );

    sticky_flag u_ovf_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set      (set_vec.ovf),
        .clear    (flag_clear.ovf),
        .enable   (irq_enable.ovf),
        .flag     (flags.ovf),
        .request  (req.ovf)
    );

    sticky_flag u_pit_flag (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set      (set_vec.periodic_tick_timer),
        .clear    (flag_clear.periodic_tick_timer),
        .enable   (irq_enable.periodic_tick_timer),
        .flag     (flags.periodic_tick_timer),
        .request  (req.periodic_tick_timer)
    );

    // Interrupt lines; no sleep gating, so they also serve as wake sources
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rtc_irq <= 1'b0;
            pit_irq <= 1'b0;
        end else begin
            rtc_irq <= req.cmp | req.ovf;
            pit_irq <= req.periodic_tick_timer;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_count_incr: assert property (count_step && !hit_per
        |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not advance");

    a_ovf_wrap: assert property (count_step && hit_per
        |=> cnt_reg == 16'h0000 && ovf_event ##1 !ovf_event)
        else $error("overflow wrap missing");

    a_cmp_event: assert property (count_step && hit_cmp
        |=> cmp_event && flags.cmp)
        else $error("compare event missing");

    a_cmp_quiet: assert property (!cmp_set |=> !cmp_event)
        else $error("spurious compare event");

    a_cnt_hold: assert property (!ctrl.counter_enable_bit
        |=> $stable(cnt_reg) && !counter_running)
        else $error("counter moved while off");

    a_pit_flag: assert property (pit_hit && irq_enable.periodic_tick_timer
        |=> flags.periodic_tick_timer ##1 pit_irq)
        else $error("tick timer flag missing");

    a_rtc_irq: assert property (flags.ovf && irq_enable.ovf
        && $past(irq_enable.ovf) |=> rtc_irq)
        else $error("overflow request missing");

    a_ulp_div: assert property (ulp32_tick_reg |-> $past(ulp_tick))
        else $error("divided tick without source tick");

    // Events always come with their flags, overflow events also with the wrapped count
    a_ovf_quiet: assert property (!ovf_set
        |=> !ovf_event)
        else $error("spurious overflow event");

    a_ovf_flag: assert property (ovf_event
        |-> flags.ovf && count_value == 16'h0000)
        else $error("overflow event without flag");

    a_cmp_flag: assert property (cmp_event
        |-> flags.cmp)
        else $error("compare event without flag");

    a_step_needs_en: assert property ($changed(cnt_reg)
        |-> $past(ctrl.counter_enable_bit))
        else $error("counter moved without enable");

    // Stopped functions stay quiet
    a_cmp_hold_off: assert property (!ctrl.counter_enable_bit && !flags.cmp
        |=> !flags.cmp)
        else $error("compare flag set while off");

    a_pit_idle: assert property (!pit_ctrl.pit_enable && !flags.periodic_tick_timer
        |=> !flags.periodic_tick_timer)
        else $error("tick flag set while off");

    a_pre_stop: assert property (!pre_run
        |=> pit_events == 8'h00)
        else $error("level events while prescaler off");

    a_rtc_idle: assert property (!flags.cmp && !flags.ovf
        |=> !rtc_irq)
        else $error("counter request without flag");

    a_pit_irq_idle: assert property (!flags.periodic_tick_timer
        |=> !pit_irq)
        else $error("tick request without flag");

    c_ovf: cover property (ovf_set ##1 ovf_event);
    c_cmp: cover property (cmp_set ##1 flags.cmp);
    c_pit: cover property (pit_hit && !ctrl.counter_enable_bit);
    c_irq: cover property (rtc_irq ##1 flag_clear.ovf ##1 !flags.ovf);
    c_ulp32: cover property (ulp32_tick_reg && ctrl.clock_source_select == rtc_pkg::SRC_ULP_DIV);

endmodule
`default_nettype wire

//--- logic/ref_prescaler.sv
// Shared reference prescaler with spread crystal correction
`timescale 1ns/1ps
`default_nettype none
module ref_prescaler #(
    parameter int CORR_INTERVAL = rtc_pkg::CORR_INTERVAL
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              run,
    input  wire logic              ref_tick,
    input  wire logic              corr_on,
    input  wire logic signed [7:0] corr_value,
    output logic [15:0]            pre_cnt
);

    logic [19:0]       ic_reg;
    logic [19:0]       acc_reg;
    logic              act_reg;
    logic signed [7:0] val_reg;
    logic [7:0]        mag;
    logic [19:0]       acc_sum;
    logic              apply;
    logic              last;
    logic [1:0]        step;

    // Magnitude clamped to the correction limit
    assign mag = (val_reg == -8'sh80) ? rtc_pkg::CORR_MAX
               : (val_reg < 0) ? 8'(-val_reg) : 8'(val_reg);

    // Spread mag corrections evenly over the interval
    assign acc_sum = acc_reg + {12'h000, mag};
    assign apply   = act_reg && (acc_sum >= 20'(CORR_INTERVAL));
    assign last    = ic_reg == 20'(CORR_INTERVAL - 1);

    // Positive skips a count, negative holds one
    assign step = !apply ? rtc_pkg::STEP_NORM
                : (val_reg > 0) ? rtc_pkg::STEP_SKIP
                : rtc_pkg::STEP_HOLD;

    // Prescale counter and correction interval state
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            pre_cnt <= rtc_pkg::PRE_RESET;
            ic_reg  <= 20'h00000;
            acc_reg <= 20'h00000;
            act_reg <= 1'b0;
            val_reg <= 8'sh00;
        end else if (ref_tick) begin
            pre_cnt <= pre_cnt + {14'h0000, step};
            ic_reg  <= last ? 20'h00000 : ic_reg + 20'h00001;
            acc_reg <= last ? 20'h00000
                     : apply ? acc_sum - 20'(CORR_INTERVAL) : acc_sum;
            if (last) begin
                act_reg <= corr_on;
                val_reg <= corr_value;
            end
        end
    end

    generate
        if (CORR_INTERVAL < 256 || CORR_INTERVAL > 1048575) begin : g_bad
            $error("CORR_INTERVAL out of range");
        end
    endgenerate

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_skip_two: assert property (run && ref_tick && step == rtc_pkg::STEP_SKIP
        |=> pre_cnt == $past(pre_cnt) + 16'h0002)
        else $error("skip did not add two");
    a_hold_keep: assert property (run && ref_tick && step == rtc_pkg::STEP_HOLD
        |=> $stable(pre_cnt))
        else $error("hold moved prescaler");
    a_stop_clear: assert property (!run |=> pre_cnt == 16'h0000)
        else $error("prescaler ran while off");

endmodule
`default_nettype wire

//--- logic/rtc_pkg.sv
// Shared constants, types and helpers of the real-time counter core
package rtc_pkg;

    // Widths
    localparam int CNT_W     = 16;
    localparam int PRE_W     = 16;
    localparam int PRESC_W   = 4;
    localparam int CORR_W    = 8;
    localparam int INT_W     = 20;
    localparam int PIT_EVT_N = 8;

    // Correction limits and spreading interval in reference cycles
    localparam logic [7:0] CORR_MAX      = 8'h7F;
    localparam int         CORR_INTERVAL = 1000000;

    // Reference divider for the low-power oscillator
    localparam logic [4:0] ULP_DIV_LAST = 5'h1F;

    // Periodic tick timer period select range
    localparam logic [3:0] PIT_SEL_MIN = 4'h1;
    localparam logic [3:0] PIT_SEL_MAX = 4'hE;
    localparam int         PIT_EVT_LSB = 5;

    // Reset values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] PRE_RESET = 16'h0000;

    // Prescaler advance per reference cycle
    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_NORM = 2'h1;
    localparam logic [1:0] STEP_SKIP = 2'h2;

    typedef enum logic [1:0] {
        SRC_XTAL,
        SRC_EXT,
        SRC_ULP,
        SRC_ULP_DIV
    } src_t;

    typedef struct packed {
        logic              counter_enable_bit;
        logic [3:0]        prescale;
        src_t              clock_source_select;
        logic              corr_enable;
        logic signed [7:0] corr_value;
    } rtc_ctrl_t;

    typedef struct packed {
        logic       pit_enable;
        logic [3:0] period;
    } pit_ctrl_t;

    // Per-source bits: compare, overflow, periodic tick
    typedef struct packed {
        logic cmp;
        logic ovf;
        logic periodic_tick_timer;
    } flags_t;

    // True when a carry left the low sh bits between two counts
    function automatic logic crossed(input logic [15:0] prev,
                                     input logic [15:0] cur,
                                     input logic [3:0]  sh);
        logic [15:0] d;
        d = (prev ^ cur) >> sh;
        return d != 16'h0000;
    endfunction

endpackage

//--- logic/sticky_flag.sv
// Sticky event flag with enable-gated request
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clear,
    input  wire logic enable,
    output logic      flag,
    output logic      request
);

    logic flag_next;

    // Set wins over a clear in the same cycle
    assign flag_next = set | (flag & ~clear);

    // Flag and request registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag    <= 1'b0;
            request <= 1'b0;
        end else begin
            flag    <= flag_next;
            request <= flag_next & enable;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_set_wins: assert property (set |=> flag)
        else $error("flag lost its set");
    a_req_flag: assert property (request |-> flag)
        else $error("request without flag");
    a_clear_drop: assert property (clear && !set |=> !flag && !request)
        else $error("clear did not drop flag");

endmodule
`default_nettype wire

//--- tb/real_time_counter_core_tb.sv
// Self-checking testbench for the real-time counter core
`timescale 1ns/1ps
`default_nettype none
module real_time_counter_core_tb;
    localparam int CORR_INT = 256;

    logic                core_clk;
    logic                rst_n;
    logic                xtal_tick;
    logic                ext_clk_tick;
    logic                ulp_tick;
    rtc_pkg::rtc_ctrl_t  ctrl;
    rtc_pkg::pit_ctrl_t  pit_ctrl;
    rtc_pkg::flags_t     irq_enable;
    rtc_pkg::flags_t     flag_clear;
    logic [15:0]         period_value;
    logic [15:0]         compare_value;
    logic [15:0]         count_value;
    rtc_pkg::flags_t     flags;
    logic                rtc_irq;
    logic                pit_irq;
    logic                cmp_event;
    logic                ovf_event;
    logic                counter_running;
    logic [7:0]          pit_events;
    int                  num_errors;
    int                  checks;
    int                  ovf_seen;
    int                  cmp_seen;

    real_time_counter_core #(.CORR_INTERVAL(CORR_INT)) i_real_time_counter_core (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .xtal_tick       (xtal_tick),
        .ext_clk_tick    (ext_clk_tick),
        .ulp_tick        (ulp_tick),
        .ctrl            (ctrl),
        .pit_ctrl        (pit_ctrl),
        .irq_enable      (irq_enable),
        .flag_clear      (flag_clear),
        .period_value    (period_value),
        .compare_value   (compare_value),
        .count_value     (count_value),
        .flags           (flags),
        .rtc_irq         (rtc_irq),
        .pit_irq         (pit_irq),
        .cmp_event       (cmp_event),
        .ovf_event       (ovf_event),
        .counter_running (counter_running),
        .pit_events      (pit_events)
    );

    // Clock generation, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Pulse counters for the event outputs
    always @(posedge core_clk) begin
        if (ovf_event === 1'b1) ovf_seen++;
        if (cmp_event === 1'b1) cmp_seen++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Short reset, all controls back to idle
    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        ctrl <= '0;
        pit_ctrl <= '0;
        irq_enable <= '0;
        flag_clear <= '0;
        period_value <= 16'hFFFF;
        compare_value <= 16'hFFFF;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        ovf_seen = 0;
        cmp_seen = 0;
        #1;
    endtask

    // Setup in the required order: source, values, enables, prescale, run
    task automatic cfg(input rtc_pkg::src_t s, input logic [3:0] p, input logic [15:0] per,
                       input logic [15:0] cv, input rtc_pkg::flags_t ie, input logic en);
        @(posedge core_clk) ctrl.clock_source_select <= s;
        @(posedge core_clk) begin
            period_value <= per;
            compare_value <= cv;
        end
        @(posedge core_clk) irq_enable <= ie;
        @(posedge core_clk) ctrl.prescale <= p;
        @(posedge core_clk) ctrl.counter_enable_bit <= en;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Drive reference ticks on one source: 0 crystal, 1 external, 2 low-power
    task automatic ticks(input int n, input int gap, input int w);
        @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            xtal_tick <= (w == 0);
            ext_clk_tick <= (w == 1);
            ulp_tick <= (w == 2);
            @(posedge core_clk);
            if (gap > 0) begin
                {xtal_tick, ext_clk_tick, ulp_tick} <= 3'h0;
                repeat (gap) @(posedge core_clk);
            end
        end
        {xtal_tick, ext_clk_tick, ulp_tick} <= 3'h0;
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse_clear(input rtc_pkg::flags_t f);
        @(posedge core_clk) flag_clear <= f;
        @(posedge core_clk) flag_clear <= '0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset_values();
        check(count_value, 16'h0000);
        check(16'(flags), 16'h0000);
        check(16'({rtc_irq, pit_irq, cmp_event, ovf_event, counter_running}), 16'h0000);
        check(16'(pit_events), 16'h0000);
    endtask

    task automatic t_count_prescale();
        do_reset();
        cfg(rtc_pkg::SRC_XTAL, 4'h2, 16'hFFFF, 16'hFFFF, '0, 1'b1);
        check(16'(counter_running), 16'h0001);
        ticks(7, 3, 0);
        check(count_value, 16'h0001);
        ticks(1, 3, 0);
        check(count_value, 16'h0002);
        @(posedge core_clk) ctrl.counter_enable_bit <= 1'b0;
        ticks(8, 3, 0);
        check(count_value, 16'h0002);
        check(16'(counter_running), 16'h0000);
    endtask

    task automatic t_overflow();
        do_reset();
        cfg(rtc_pkg::SRC_XTAL, 4'h0, 16'h0003, 16'hFFFF, rtc_pkg::flags_t'(3'h2), 1'b1);
        ticks(3, 3, 0);
        check(count_value, 16'h0003);
        check(16'(ovf_seen), 16'h0000);
        ticks(1, 3, 0);
        check(count_value, 16'h0000);
        check(16'(ovf_seen), 16'h0001);
        check(16'({flags.ovf, rtc_irq}), 16'h0003);
        ticks(4, 0, 0);
        check(16'(ovf_seen), 16'h0002);
        @(posedge core_clk) irq_enable <= '0;
        repeat (3) @(posedge core_clk);
        #1;
        check(16'({flags.ovf, rtc_irq}), 16'h0002);
        @(posedge core_clk) irq_enable <= rtc_pkg::flags_t'(3'h2);
        repeat (3) @(posedge core_clk);
        #1;
        check(16'(rtc_irq), 16'h0001);
        pulse_clear(rtc_pkg::flags_t'(3'h2));
        check(16'({flags.ovf, rtc_irq}), 16'h0000);
    endtask

    task automatic t_compare();
        do_reset();
        cfg(rtc_pkg::SRC_XTAL, 4'h0, 16'hFFFF, 16'h0002, rtc_pkg::flags_t'(3'h4), 1'b1);
        ticks(2, 3, 0);
        check(16'(cmp_seen), 16'h0000);
        check(16'(flags), 16'h0000);
        ticks(1, 3, 0);
        check(16'(cmp_seen), 16'h0001);
        check(16'({flags, rtc_irq}), 16'h0009);
    endtask

    task automatic t_sources();
        for (int w = 0; w < 3; w++) begin
            do_reset();
            cfg(rtc_pkg::src_t'(w), 4'h0, 16'hFFFF, 16'hFFFF, '0, 1'b1);
            ticks(2, 3, (w + 1) % 3);
            ticks(2, 3, (w + 2) % 3);
            check(count_value, 16'h0000);
            ticks(2, 3, w);
            check(count_value, 16'h0002);
        end
        do_reset();
        cfg(rtc_pkg::SRC_ULP_DIV, 4'h0, 16'hFFFF, 16'hFFFF, '0, 1'b1);
        ticks(31, 1, 2);
        check(count_value, 16'h0000);
        ticks(1, 1, 2);
        check(count_value, 16'h0001);
    endtask

    task automatic t_pit();
        do_reset();
        @(posedge core_clk) pit_ctrl <= '{pit_enable: 1'b1, period: 4'h1};
        cfg(rtc_pkg::SRC_XTAL, 4'h0, 16'hFFFF, 16'hFFFF, rtc_pkg::flags_t'(3'h1), 1'b0);
        ticks(3, 3, 0);
        check(16'({flags.periodic_tick_timer, pit_irq}), 16'h0000);
        ticks(1, 3, 0);
        check(16'({flags.periodic_tick_timer, pit_irq}), 16'h0003);
        check(count_value, 16'h0000);
        ticks(28, 0, 0);
        check(16'(pit_events), 16'h0001);
        ticks(32, 0, 0);
        check(16'(pit_events), 16'h0002);
        pulse_clear(rtc_pkg::flags_t'(3'h1));
        ticks(2, 3, 0);
        @(posedge core_clk) pit_ctrl.pit_enable <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check(16'(pit_events), 16'h0000);
        @(posedge core_clk) pit_ctrl.pit_enable <= 1'b1;
        ticks(3, 3, 0);
        check(16'(flags.periodic_tick_timer), 16'h0000);
        ticks(1, 3, 0);
        check(16'(flags.periodic_tick_timer), 16'h0001);
        do_reset();
        @(posedge core_clk) pit_ctrl <= '{pit_enable: 1'b1, period: 4'hE};
        ticks(32767, 0, 0);
        check(16'(flags.periodic_tick_timer), 16'h0000);
        ticks(1, 3, 0);
        check(16'(flags.periodic_tick_timer), 16'h0001);
        // Refused period select gives no ticks
        do_reset();
        @(posedge core_clk) pit_ctrl <= '{pit_enable: 1'b1, period: 4'hF};
        ticks(16, 0, 0);
        check(16'(flags.periodic_tick_timer), 16'h0000);
    endtask

    // Corrected count over three intervals, prescale divide by two
    task automatic t_corr(input logic signed [7:0] v, input int w, input int lo, input int hi);
        do_reset();
        @(posedge core_clk) begin
            ctrl.corr_value <= v;
            ctrl.corr_enable <= 1'b1;
        end
        cfg(rtc_pkg::src_t'(w), 4'h1, 16'hFFFF, 16'hFFFF, '0, 1'b1);
        ticks(3 * CORR_INT, 0, w);
        check(16'(count_value >= 16'(lo) && count_value <= 16'(hi)), 16'h0001);
    endtask

    // Watchdog for a hung run
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        num_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        {xtal_tick, ext_clk_tick, ulp_tick} = 3'h0;
        ctrl = '0;
        pit_ctrl = '0;
        irq_enable = '0;
        flag_clear = '0;
        period_value = 16'hFFFF;
        compare_value = 16'hFFFF;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        t_reset_values();
        t_count_prescale();
        t_overflow();
        t_compare();
        t_sources();
        t_pit();
        t_corr(8'sh03, 0, 385, 388);
        t_corr(-8'sh03, 0, 379, 382);
        t_corr(8'sh03, 1, 384, 384);
        tally_and_finish();
    end
endmodule
`default_nettype wire
